// >>> rtl/ticd_cfg.svh
`ifndef TICD_CFG_SVH
`define TICD_CFG_SVH

// register byte offsets on the AXI4-Lite port
`define TICD_OFS_CH0_IOCTL   12'h000
`define TICD_OFS_CH1_IOCTL   12'h004
`define TICD_OFS_CH2_IOCTL   12'h008
`define TICD_OFS_CTRL        12'h00C
`define TICD_OFS_CH0_GR_D    12'h010
`define TICD_OFS_CH1_GR_B    12'h014
`define TICD_OFS_CH2_GR_B    12'h018
`define TICD_OFS_STATUS      12'h01C

// reset values
`define TICD_RST_IOCTL       8'h00
`define TICD_RST_CTRL        7'h00
`define TICD_RST_GR          16'h0000
`define TICD_RST_DATA32      32'h0000_0000

// field positions inside an io control register
`define TICD_FLD_HI          7
`define TICD_FLD_LO          4
// inside a four-bit field
`define TICD_FLD_CAPT        3
`define TICD_FLD_LEVEL       2
`define TICD_FLD_ALT         2
`define TICD_FLD_BOTH        1
`define TICD_FLD_FALL        0

// control register fields
`define TICD_CTRL_BFB        0
`define TICD_CTRL_PSC_LO     1
`define TICD_CTRL_PSC_HI     3
`define TICD_CTRL_RUN_LO     4
`define TICD_CTRL_RUN_HI     6

// prescaler code that selects the undivided clock
`define TICD_PSC_UNDIVIDED   3'h0

// compare actions on the low two field bits
`define TICD_ACT_NONE        2'h0
`define TICD_ACT_LOW         2'h1
`define TICD_ACT_HIGH        2'h2
`define TICD_ACT_TOGGLE      2'h3

// bus responses
`define TICD_RESP_OKAY       2'h0
`define TICD_RESP_SLVERR     2'h2

`endif

// >>> rtl/ticd_pkg.sv
package ticd_pkg;

  // role decoded from a four-bit io control field
  typedef enum logic [2:0] {
    TICD_MODE_OFF,
    TICD_MODE_OC,
    TICD_MODE_IC_RISE,
    TICD_MODE_IC_FALL,
    TICD_MODE_IC_BOTH,
    TICD_MODE_IC_ALT
  } ticd_mode_t;

  // per channel configuration
  typedef struct packed {
    logic [3:0] field;
    logic       run;
    logic       en;
    logic       alt_ok;
  } ticd_chan_cfg_t;

  // one timer pin drive
  typedef struct packed {
    logic o;
    logic oe;
  } ticd_pin_t;

endpackage

// >>> rtl/ticd_sync.sv
`timescale 1ns/1ps
module ticd_sync (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // raw pin
  input  wire logic d,
  // synchronised level and edge pulses
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // two flops, then one more to find edges; meta_ff feeds sync_ff only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= d; // RQ14
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  // edge pulses last one cycle each
  assign level = sync_ff;
  assign rise  = sync_ff & ~last_ff;
  assign fall  = ~sync_ff & last_ff;

endmodule

// >>> rtl/ticd_chan.sv
`timescale 1ns/1ps
`include "ticd_cfg.svh"
module ticd_chan (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // configuration
  input  ticd_pkg::ticd_chan_cfg_t cfg,
  // counter, cascade event, pin
  input  wire logic [15:0]       count,
  input  wire logic              alt_evt,
  input  wire logic              pin_i,
  // software write of the general register
  input  wire logic              gr_we,
  input  wire logic [15:0]       gr_wdata,
  // results
  output logic [15:0]            gr_q,
  output ticd_pkg::ticd_pin_t    pin,
  output logic                   pin_lvl,
  output logic                   capt
);

  ticd_pkg::ticd_mode_t mode;
  logic [15:0] gr_ff;
  logic        pin_o_ff;
  logic        pin_oe_ff;
  logic        match_ff;
  logic        nxt_pin_o;
  logic        rise;
  logic        fall;
  logic        match_now;
  logic        match_edge;
  logic [1:0]  act;

  // capture pin synchroniser and edge finder
  ticd_sync u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (pin_i),
    .level   (pin_lvl),
    .rise    (rise),
    .fall    (fall)
  );

  // field decode; a disabled channel has no role
  always_comb begin
    if (!cfg.en) begin
      mode = ticd_pkg::TICD_MODE_OFF;
    end else if (!cfg.field[`TICD_FLD_CAPT]) begin
      mode = ticd_pkg::TICD_MODE_OC;
    end else if (cfg.field[`TICD_FLD_ALT] && cfg.alt_ok) begin
      mode = ticd_pkg::TICD_MODE_IC_ALT;
    end else if (cfg.field[`TICD_FLD_BOTH]) begin
      mode = ticd_pkg::TICD_MODE_IC_BOTH;
    end else if (cfg.field[`TICD_FLD_FALL]) begin
      mode = ticd_pkg::TICD_MODE_IC_FALL;
    end else begin
      mode = ticd_pkg::TICD_MODE_IC_RISE;
    end
  end

  // capture qualification per role
  always_comb begin
    case (mode)
      ticd_pkg::TICD_MODE_IC_RISE: capt = rise;
      ticd_pkg::TICD_MODE_IC_FALL: capt = fall;
      ticd_pkg::TICD_MODE_IC_BOTH: capt = rise | fall;
      ticd_pkg::TICD_MODE_IC_ALT:  capt = alt_evt;
      default:                     capt = 1'b0;
    endcase
  end

  // compare fires once when the counter reaches the register
  assign act        = cfg.field[1:0];
  assign match_now  = (count == gr_ff);
  assign match_edge = match_now & ~match_ff;

  // output level: preset while stopped, action on match while running
  always_comb begin
    nxt_pin_o = pin_o_ff;
    if (mode == ticd_pkg::TICD_MODE_OC) begin
      if (!cfg.run) begin
        nxt_pin_o = cfg.field[`TICD_FLD_LEVEL]; // RQ1 RQ12
      end else if (match_edge) begin
        case (act)
          `TICD_ACT_LOW:    nxt_pin_o = 1'b0;      // RQ3
          `TICD_ACT_HIGH:   nxt_pin_o = 1'b1;      // RQ4
          `TICD_ACT_TOGGLE: nxt_pin_o = ~pin_o_ff; // RQ5
          default:          nxt_pin_o = pin_o_ff;
        endcase
      end
    end
  end

  // capture wins over a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gr_ff     <= `TICD_RST_GR;
      pin_o_ff  <= 1'b0;
      pin_oe_ff <= 1'b0;
      match_ff  <= 1'b0;
    end else begin
      if (capt) begin
        gr_ff <= count; // RQ6 RQ7 RQ8
      end else if (gr_we) begin
        gr_ff <= gr_wdata;
      end
      pin_o_ff  <= nxt_pin_o;
      pin_oe_ff <= (mode == ticd_pkg::TICD_MODE_OC) && (act != `TICD_ACT_NONE); // RQ2
      match_ff  <= match_now;
    end
  end

  assign gr_q   = gr_ff;
  assign pin.o  = pin_o_ff;
  assign pin.oe = pin_oe_ff;

endmodule

// >>> rtl/ticd_top.sv
// Function
// RQ1 - field top bit 0 selects compare; bit 6 chooses preset pin level
// RQ2 - compare with low bits 00 disables the pin; all-zero is reset state
// RQ3 - compare with low bits 01 drives pin low on each match
// RQ4 - compare with low bits 10 drives pin high on each match
// RQ5 - compare with low bits 11 toggles pin on each match
// RQ6 - field 1000 captures counter on rising edge of own pin
// RQ7 - field 1001 captures counter on falling edge of own pin
// RQ8 - field 101x captures counter on both pin edges
// RQ9 - ch0 D 11xx captures on ch1 count ticks, never when prescaler is 000
// RQ10 - ch1 B 11xx captures on ch0 C compare match or capture events
// RQ11 - buffer select makes ch0 D a plain buffer with no capture or compare
// RQ12 - preset pin level applies only while the channel counter is stopped
// RQ13 - io control registers clear on reset and standby, not module standby
// RQ14 - capture pins are synchronised before edge detection, one capture per edge
`timescale 1ns/1ps
`include "ticd_cfg.svh"
module ticd_top (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  // axi4-lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // counters of the three channels
  input  wire logic [15:0] ch0_count,
  input  wire logic [15:0] ch1_count,
  input  wire logic [15:0] ch2_count,
  // cascade event sources
  input  wire logic        ch1_count_tick,
  input  wire logic        ch0_c_event,
  // power states
  input  wire logic        hw_standby,
  input  wire logic        sw_standby,
  input  wire logic        module_standby,
  // timer pins
  input  wire logic        ch0_pin_d_i,
  output logic             ch0_pin_d_o,
  output logic             ch0_pin_d_oe,
  input  wire logic        ch1_pin_b_i,
  output logic             ch1_pin_b_o,
  output logic             ch1_pin_b_oe,
  input  wire logic        ch2_pin_b_i,
  output logic             ch2_pin_b_o,
  output logic             ch2_pin_b_oe
);

  // software visible state
  logic [7:0]  ch0_io_control_low_ff;
  logic [7:0]  ch1_io_control_ff;
  logic [7:0]  ch2_io_control_ff;
  logic [6:0]  ctrl_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [1:0]  rresp_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  // write decode
  wire         wr_go;
  wire         wr_lane0;
  wire         wr_lane1;
  wire         wr_io0;
  wire         wr_io1;
  wire         wr_io2;
  wire         wr_ctrl;
  wire         wr_gr0;
  wire         wr_gr1;
  wire         wr_gr2;
  wire         wr_hit;
  wire         io_clear;
  wire [15:0]  gr_wdata;

  // read decode
  wire         rd_go;
  wire         rd_hit;

  // control fields
  wire         b_buffer_select;
  wire [2:0]   prescaler_select;
  wire [2:0]   counter_run_bit;

  // per channel wiring, index 0 = ch0 D, 1 = ch1 B, 2 = ch2 B
  ticd_pkg::ticd_chan_cfg_t cfg [3];
  ticd_pkg::ticd_pin_t      pin [3];
  logic [15:0] gr_q    [3];
  logic [15:0] count   [3];
  logic        alt_evt [3];
  logic        pin_i   [3];
  logic        gr_we   [3];
  logic        pin_lvl [3];
  logic        capt    [3];
  logic [3:0]  field   [3];
  wire         ch0_alt_valid;

  // write is taken when address and data are both offered and no response is pending
  assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign wr_lane0      = s_axi_wstrb[0];
  assign wr_lane1      = s_axi_wstrb[1];
  assign wr_io0        = wr_go & (s_axi_awaddr == `TICD_OFS_CH0_IOCTL);
  assign wr_io1        = wr_go & (s_axi_awaddr == `TICD_OFS_CH1_IOCTL);
  assign wr_io2        = wr_go & (s_axi_awaddr == `TICD_OFS_CH2_IOCTL);
  assign wr_ctrl       = wr_go & (s_axi_awaddr == `TICD_OFS_CTRL);
  assign wr_gr0        = wr_go & (s_axi_awaddr == `TICD_OFS_CH0_GR_D);
  assign wr_gr1        = wr_go & (s_axi_awaddr == `TICD_OFS_CH1_GR_B);
  assign wr_gr2        = wr_go & (s_axi_awaddr == `TICD_OFS_CH2_GR_B);
  assign wr_hit        = wr_io0 | wr_io1 | wr_io2 | wr_ctrl | wr_gr0 | wr_gr1 | wr_gr2
                         | (wr_go & (s_axi_awaddr == `TICD_OFS_STATUS));
  // general registers take both low lanes together only
  assign gr_wdata      = s_axi_wdata[15:0];

  // standby clears the io fields; module standby leaves them alone
  assign io_clear      = hw_standby | sw_standby; // RQ13

  // io control registers, lane 0 only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ch0_io_control_low_ff <= `TICD_RST_IOCTL; // RQ13
      ch1_io_control_ff     <= `TICD_RST_IOCTL;
      ch2_io_control_ff     <= `TICD_RST_IOCTL;
    end else if (io_clear) begin
      ch0_io_control_low_ff <= `TICD_RST_IOCTL; // RQ13
      ch1_io_control_ff     <= `TICD_RST_IOCTL;
      ch2_io_control_ff     <= `TICD_RST_IOCTL;
    end else begin
      if (wr_io0 && wr_lane0) begin
        ch0_io_control_low_ff <= s_axi_wdata[7:0];
      end
      if (wr_io1 && wr_lane0) begin
        ch1_io_control_ff <= s_axi_wdata[7:0];
      end
      if (wr_io2 && wr_lane0) begin
        ch2_io_control_ff <= s_axi_wdata[7:0];
      end
    end
  end

  // control register: buffer select, ch1 prescaler, run bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= `TICD_RST_CTRL;
    end else if (wr_ctrl && wr_lane0) begin
      ctrl_ff <= s_axi_wdata[6:0];
    end
  end

  assign b_buffer_select  = ctrl_ff[`TICD_CTRL_BFB];
  assign prescaler_select = ctrl_ff[`TICD_CTRL_PSC_HI:`TICD_CTRL_PSC_LO];
  assign counter_run_bit  = ctrl_ff[`TICD_CTRL_RUN_HI:`TICD_CTRL_RUN_LO];

  // write response one cycle after the write is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `TICD_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_hit ? `TICD_RESP_OKAY : `TICD_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // read is taken whenever no answer is pending
  assign rd_go         = s_axi_arvalid & ~rvalid_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign rd_hit        = (s_axi_araddr == `TICD_OFS_CH0_IOCTL)
                       | (s_axi_araddr == `TICD_OFS_CH1_IOCTL)
                       | (s_axi_araddr == `TICD_OFS_CH2_IOCTL)
                       | (s_axi_araddr == `TICD_OFS_CTRL)
                       | (s_axi_araddr == `TICD_OFS_CH0_GR_D)
                       | (s_axi_araddr == `TICD_OFS_CH1_GR_B)
                       | (s_axi_araddr == `TICD_OFS_CH2_GR_B)
                       | (s_axi_araddr == `TICD_OFS_STATUS);

  // read mux; narrow registers sit in the low bits
  always_comb begin
    nxt_rdata = `TICD_RST_DATA32;
    case (s_axi_araddr)
      `TICD_OFS_CH0_IOCTL: nxt_rdata[7:0]  = ch0_io_control_low_ff;
      `TICD_OFS_CH1_IOCTL: nxt_rdata[7:0]  = ch1_io_control_ff;
      `TICD_OFS_CH2_IOCTL: nxt_rdata[7:0]  = ch2_io_control_ff;
      `TICD_OFS_CTRL:      nxt_rdata[6:0]  = ctrl_ff;
      `TICD_OFS_CH0_GR_D:  nxt_rdata[15:0] = gr_q[0];
      `TICD_OFS_CH1_GR_B:  nxt_rdata[15:0] = gr_q[1];
      `TICD_OFS_CH2_GR_B:  nxt_rdata[15:0] = gr_q[2];
      `TICD_OFS_STATUS: begin
        nxt_rdata[2:0] = {pin[2].o, pin[1].o, pin[0].o};
        nxt_rdata[5:3] = {pin[2].oe, pin[1].oe, pin[0].oe};
        nxt_rdata[8:6] = {pin_lvl[2], pin_lvl[1], pin_lvl[0]};
      end
      default:             nxt_rdata = `TICD_RST_DATA32;
    endcase
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= `TICD_RESP_OKAY;
      rdata_ff  <= `TICD_RST_DATA32;
    end else if (rd_go) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= rd_hit ? `TICD_RESP_OKAY : `TICD_RESP_SLVERR;
      rdata_ff  <= nxt_rdata;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp  = rresp_ff;
  assign s_axi_rdata  = rdata_ff;

  // cascade: undivided ch1 clock gives no capture source
  assign ch0_alt_valid = ch1_count_tick & (prescaler_select != `TICD_PSC_UNDIVIDED); // RQ9

  // per channel inputs
  assign field[0]   = ch0_io_control_low_ff[`TICD_FLD_HI:`TICD_FLD_LO];
  assign field[1]   = ch1_io_control_ff[`TICD_FLD_HI:`TICD_FLD_LO];
  assign field[2]   = ch2_io_control_ff[`TICD_FLD_HI:`TICD_FLD_LO];
  assign count[0]   = ch0_count;
  assign count[1]   = ch1_count;
  assign count[2]   = ch2_count;
  assign alt_evt[0] = ch0_alt_valid;  // RQ9
  assign alt_evt[1] = ch0_c_event;    // RQ10
  assign alt_evt[2] = 1'b0;
  assign pin_i[0]   = ch0_pin_d_i;
  assign pin_i[1]   = ch1_pin_b_i;
  assign pin_i[2]   = ch2_pin_b_i;
  assign gr_we[0]   = wr_gr0 & wr_lane0 & wr_lane1;
  assign gr_we[1]   = wr_gr1 & wr_lane0 & wr_lane1;
  assign gr_we[2]   = wr_gr2 & wr_lane0 & wr_lane1;

  // the three capture/compare units
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_chan
      // ch2 has no cascade source, so 11xx falls back to pin edges
      assign cfg[gi].field  = field[gi];
      assign cfg[gi].run    = counter_run_bit[gi];
      // a buffered ch0 D has no role of its own
      assign cfg[gi].en     = (gi == 0) ? ~b_buffer_select : 1'b1; // RQ11
      assign cfg[gi].alt_ok = (gi != 2);

      ticd_chan u_chan (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .cfg      (cfg[gi]),
        .count    (count[gi]),
        .alt_evt  (alt_evt[gi]),
        .pin_i    (pin_i[gi]), // RQ14
        .gr_we    (gr_we[gi]),
        .gr_wdata (gr_wdata),
        .gr_q     (gr_q[gi]),
        .pin      (pin[gi]),
        .pin_lvl  (pin_lvl[gi]),
        .capt     (capt[gi])
      );
    end
  endgenerate

  // pin drives
  assign ch0_pin_d_o  = pin[0].o;
  assign ch0_pin_d_oe = pin[0].oe;
  assign ch1_pin_b_o  = pin[1].o;
  assign ch1_pin_b_oe = pin[1].oe;
  assign ch2_pin_b_o  = pin[2].o;
  assign ch2_pin_b_oe = pin[2].oe;

endmodule

// >>> testbench/ticd_props.sv
`timescale 1ns/1ps
module ticd_props (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus write side
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_bvalid,
  // channel 2 and standby
  input wire logic [15:0] ch2_count,
  input wire logic        hw_standby,
  input wire logic        sw_standby,
  input wire logic        ch2_pin_b_o,
  input wire logic        ch2_pin_b_oe
);
  logic [3:0]  f2_ff;
  logic [3:0]  fd_ff;
  logic        run_ff;
  logic        rd_ff;
  logic        eq_ff;
  logic [15:0] gr_ff;
  logic        wr_hit;
  logic        eq;
  logic        stl;
  logic        m;
  // shadow decode; settled means compare field unchanged for a cycle
  assign wr_hit = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign eq     = ch2_count == gr_ff;
  assign stl    = !f2_ff[3] && f2_ff == fd_ff;
  assign m      = stl && run_ff && rd_ff && eq && !eq_ff;
  // standby clears only the field, so the shadow keeps that split
  always_ff @(posedge aclk) begin
    if (!aresetn || hw_standby || sw_standby) begin
      f2_ff <= 4'h0;
    end else if (wr_hit && s_axi_awaddr == 12'h008 && s_axi_wstrb[0]) begin
      f2_ff <= s_axi_wdata[7:4];
    end
  end
  // run bit and general register shadow
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_ff <= 1'b0;
      gr_ff  <= 16'h0000;
    end else if (wr_hit && s_axi_awaddr == 12'h00c && s_axi_wstrb[0]) begin
      run_ff <= s_axi_wdata[6];
    end else if (wr_hit && s_axi_awaddr == 12'h018 && s_axi_wstrb[1:0] == 2'h3) begin
      gr_ff <= s_axi_wdata[15:0];
    end
  end
  // one-cycle history, so match starts can be told from held equality
  always_ff @(posedge aclk) begin
    fd_ff <= aresetn ? f2_ff : 4'h0;
    rd_ff <= aresetn && run_ff;
    eq_ff <= aresetn && eq;
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (wr_hit |=> s_axi_bvalid)
    else $error("write not answered");
  a_oe_off: assert property (stl && f2_ff[1:0] == 2'h0 |-> !ch2_pin_b_oe)
    else $error("pin driven with action none");
  a_oe_on: assert property (stl && f2_ff[1:0] != 2'h0 |-> ch2_pin_b_oe)
    else $error("compare pin not driven");
  a_preset_level: assert property (stl && !run_ff && !rd_ff |-> ch2_pin_b_o == f2_ff[2])
    else $error("preset level wrong");
  a_match_low: assert property (m && f2_ff[1:0] == 2'h1 |=> !ch2_pin_b_o)
    else $error("match did not drive low");
  a_match_high: assert property (m && f2_ff[1:0] == 2'h2 |=> ch2_pin_b_o)
    else $error("match did not drive high");
  a_match_toggle: assert property (m && f2_ff[1:0] == 2'h3 |=> ch2_pin_b_o != $past(ch2_pin_b_o))
    else $error("match did not toggle");
  a_standby_clear: assert property (hw_standby || sw_standby |-> ##2 !ch2_pin_b_oe)
    else $error("standby left pin driven");
endmodule

bind ticd_top ticd_props u_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
  .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .ch2_count,
  .hw_standby, .sw_standby, .ch2_pin_b_o, .ch2_pin_b_oe
);

// >>> testbench/ticd_pin_model.sv
`timescale 1ns/1ps
module ticd_pin_model (
  // clock
  input wire logic        aclk,
  // pin drive from the block
  input wire logic [2:0]  pin_o,
  input wire logic [2:0]  pin_oe,
  // pin levels and counters seen by the block
  output logic [2:0]      pin_i,
  output logic [15:0]     ch0_count,
  output logic [15:0]     ch1_count,
  output logic [15:0]     ch2_count,
  // one-cycle cascade pulses
  output logic            ch1_count_tick,
  output logic            ch0_c_event
);
  logic [2:0] drv;
  // a pin the block drives shows its level, otherwise the far side's
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & drv);
  initial begin
    drv            = 3'h0;
    ch0_count      = 16'h0000;
    ch1_count      = 16'h0000;
    ch2_count      = 16'h0000;
    ch1_count_tick = 1'b0;
    ch0_c_event    = 1'b0;
  end
  // one cascade pulse of exactly one cycle
  task pulse(input logic c_evt);
    @(posedge aclk);
    ch0_c_event    <= c_evt;
    ch1_count_tick <= !c_evt;
    @(posedge aclk);
    ch0_c_event    <= 1'b0;
    ch1_count_tick <= 1'b0;
  endtask
  // held well past the synchroniser, else short pulses are missed
  task set_pin(input int k, input logic v);
    @(posedge aclk);
    drv[k] <= v;
    repeat (5) @(posedge aclk);
  endtask
  // counter value held until the next call
  task set_count(input int k, input logic [15:0] v);
    @(posedge aclk);
    ch0_count <= (k == 0) ? v : ch0_count;
    ch1_count <= (k == 1) ? v : ch1_count;
    ch2_count <= (k == 2) ? v : ch2_count;
  endtask
endmodule

// >>> testbench/timer_io_control_decode_tb_top.sv
`timescale 1ns/1ps
module timer_io_control_decode_tb_top;
  logic        aclk, aresetn, hw_standby, sw_standby, module_standby, ch1_count_tick;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, ch0_c_event;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot, pin_i;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, e;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] ch0_count, ch1_count, ch2_count;
  logic        ch0_pin_d_i, ch0_pin_d_o, ch0_pin_d_oe, ch1_pin_b_i, ch1_pin_b_o, ch1_pin_b_oe;
  logic        ch2_pin_b_i, ch2_pin_b_o, ch2_pin_b_oe;
  int          bad_count, checks, cyc;

  ticd_top dut (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .ch0_count, .ch1_count, .ch2_count, .ch1_count_tick, .ch0_c_event, .hw_standby,
    .sw_standby, .module_standby, .ch0_pin_d_i, .ch0_pin_d_o, .ch0_pin_d_oe,
    .ch1_pin_b_i, .ch1_pin_b_o, .ch1_pin_b_oe, .ch2_pin_b_i, .ch2_pin_b_o, .ch2_pin_b_oe
  );
  ticd_pin_model pm (
    .aclk, .pin_i, .ch0_count, .ch1_count, .ch2_count, .ch1_count_tick, .ch0_c_event,
    .pin_o  ({ch2_pin_b_o, ch1_pin_b_o, ch0_pin_d_o}),
    .pin_oe ({ch2_pin_b_oe, ch1_pin_b_oe, ch0_pin_d_oe})
  );
  assign {ch2_pin_b_i, ch1_pin_b_i, ch0_pin_d_i} = pin_i;

  // clock and hang guard
  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  task end_sim;
    if (bad_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ready sampled mid-cycle, where it has settled, then acted on at the edge
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic ok;
    @(posedge aclk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    s_axi_awaddr <= a;
    s_axi_wdata  <= d;
    ok = 1'b0;
    while (!ok) begin
      @(negedge aclk);
      ok = s_axi_awready === 1'b1 && s_axi_wready === 1'b1;
      @(posedge aclk);
    end
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    ok = 1'b0;
    while (!ok) begin
      @(negedge aclk);
      ok = s_axi_bvalid === 1'b1;
      rsp = s_axi_bresp;
      @(posedge aclk);
    end
    s_axi_bready <= 1'b0;
  endtask

  task rd_q(input logic [11:0] a);
    logic ok;
    @(posedge aclk);
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    s_axi_araddr <= a;
    ok = 1'b0;
    while (!ok) begin
      @(negedge aclk);
      ok = s_axi_arready === 1'b1;
      @(posedge aclk);
    end
    s_axi_arvalid <= 1'b0;
    ok = 1'b0;
    while (!ok) begin
      @(negedge aclk);
      ok = s_axi_rvalid === 1'b1;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
    end
    s_axi_rready <= 1'b0;
  endtask

  task chk(input string nm, input logic [11:0] a, input logic [31:0] x);
    rd_q(a);
    check(nm, rd, x);
  endtask

  // ch2 pin enable and level from the status word
  task pin2(input logic oe, input logic o);
    rd_q(12'h01c);
    check("ch2 oe", 32'(rd[5]), 32'(oe));
    check("ch2 out", 32'(rd[2]), 32'(o));
  endtask

  task match2;
    pm.set_count(2, 16'h0040);
    pm.set_count(2, 16'h0000);
  endtask

  initial begin
    {aclk, aresetn, hw_standby, sw_standby, module_standby} = 5'h00;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = 30'h0000_0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    bad_count = 0;
    checks = 0;
    cyc = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset contents, then unmapped places
    for (int i = 0; i < 4; i++) chk("reset", 12'(4 * i), 32'h0000_0000);
    rd_q(12'h020);
    check("rresp", 32'(rsp), 32'h0000_0002);
    check("rdata", rd, 32'h0000_0000);
    wr(12'h024, 32'h0000_00ff);
    check("bresp", 32'(rsp), 32'h0000_0002);
    // every compare field with the counter stopped
    for (int f = 0; f < 8; f++) begin
      wr(12'h008, 32'(f << 4));
      pin2(f[1:0] != 2'h0, f[2]);
    end
    // match actions while running; preset must not apply
    wr(12'h018, 32'h0000_0040);
    wr(12'h008, 32'h0000_0050);
    wr(12'h00c, 32'h0000_0040);
    match2();
    pin2(1'b1, 1'b0);
    wr(12'h008, 32'h0000_0060);
    pin2(1'b1, 1'b0);
    match2();
    pin2(1'b1, 1'b1);
    wr(12'h008, 32'h0000_0030);
    match2();
    pin2(1'b1, 1'b0);
    match2();
    pin2(1'b1, 1'b1);
    wr(12'h00c, 32'h0000_0000);
    pin2(1'b1, 1'b0);
    // each edge choice, ch2 11xx too (no cascade there); count moved away to catch late loads
    for (int f = 8; f < 16; f++) begin
      wr(12'h008, 32'(f << 4));
      wr(12'h018, 32'h0000_0000);
      pm.set_count(2, 16'h1100);
      pm.set_pin(2, 1'b1);
      pm.set_count(2, 16'hffff);
      e = (f[1:0] == 2'h0 || f[1]) ? 32'h0000_1100 : 32'h0000_0000;
      chk("rise", 12'h018, e);
      pm.set_count(2, 16'h2200);
      pm.set_pin(2, 1'b0);
      pm.set_count(2, 16'hffff);
      if (f[1:0] == 2'h1 || f[1]) e = 32'h0000_2200;
      chk("fall", 12'h018, e);
    end
    // cascades, ch0 refused while prescaler undivided
    wr(12'h004, 32'h0000_00c0);
    pm.set_count(1, 16'h0abc);
    pm.pulse(1'b1);
    chk("ch1 gr", 12'h014, 32'h0000_0abc);
    wr(12'h000, 32'h0000_00c0);
    pm.set_count(0, 16'h0123);
    pm.pulse(1'b0);
    chk("ch0 gr", 12'h010, 32'h0000_0000);
    wr(12'h00c, 32'h0000_0002);
    pm.pulse(1'b0);
    chk("ch0 gr", 12'h010, 32'h0000_0123);
    // buffer select silences ch0 D for capture and compare
    wr(12'h00c, 32'h0000_0003);
    pm.set_count(0, 16'h0555);
    pm.pulse(1'b0);
    chk("buffer", 12'h010, 32'h0000_0123);
    wr(12'h000, 32'h0000_0010);
    rd_q(12'h01c);
    check("ch0 oe", 32'(rd[3]), 32'h0000_0000);
    // module standby keeps the field, the other two clear it
    for (int k = 0; k < 3; k++) begin
      wr(12'h008, 32'h0000_0010);
      @(posedge aclk);
      {module_standby, sw_standby, hw_standby} <= 3'(1 << k);
      @(posedge aclk);
      {module_standby, sw_standby, hw_standby} <= 3'h0;
      chk("standby", 12'h008, k == 2 ? 32'h0000_0010 : 32'h0000_0000);
    end
    end_sim();
  end
endmodule
